/* File: verilog/iso_split_descriptor_fields.sv */
// How it works
// - 7-bit function address field becomes the token's device address.
// - Endpoint upper three bits in the high word, lowest bit at word0 bit 31.
// - Split max length caps the bytes moved per start split.
// - 15-bit total byte count bounds all bytes moved by a descriptor.
// - Without split, total byte count acts as the downstream max packet size.
// - Controller clears valid when done or on a fatal error.
// - Token field 00 selects OUT, 01 selects IN.
// - Split bit zero is plain high-speed, one is split through translator.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module iso_split_descriptor_fields (
  input  wire logic        mclk,       // Clock, 125 MHz
  input  wire logic        reset_n,    // Async reset, active low
  input  wire logic [4:0]  addr,       // Register byte address
  input  wire logic [31:0] wdata,      // Register write data
  input  wire logic        wr,         // Write strobe
  input  wire logic        rd,         // Read strobe
  output logic      [31:0] rdata,      // Read data, cycle after rd
  output logic             tok_valid,  // Token request
  input  wire logic        tok_ready,  // Token accepted
  output logic             tok_in,     // Token is IN
  output logic             tok_split,  // Split transaction
  output logic      [6:0]  tok_addr,   // Function address
  output logic      [3:0]  tok_endp,   // Endpoint number
  output logic      [14:0] tok_len,    // Bytes in this transaction
  output logic             tx_valid,   // OUT byte valid
  input  wire logic        tx_ready,   // OUT byte taken
  output logic      [7:0]  tx_data,    // OUT byte
  input  wire logic        rx_valid,   // IN byte valid
  output logic             rx_ready,   // IN byte taken
  input  wire logic [7:0]  rx_data,    // IN byte
  input  wire logic        fatal_err,  // Fatal link error pulse
  output logic             busy,       // Descriptor in execution
  output logic             done        // Descriptor retired pulse
);
  iso_split_pkg::state_t state_q;
  logic [31:0] w0_q;
  logic [31:0] w1_q;
  logic [31:0] w3_q;
  logic [31:0] ctrl_q;
  logic [14:0] remain_q;
  logic [14:0] chunk_q;
  logic [14:0] moved_q;
  logic        err_q;
  logic        dir_in_q;
  logic [2:0]  rsel_q;
  logic [8:0]  pop_q;
  logic [31:0] mem_rd_a;
  logic [31:0] mem_rd_b;
  logic [1:0]  mem_raddr_b;
  logic        mem_we;
  logic [1:0]  mem_waddr;
  logic [31:0] mem_wdata;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [7:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [7:0]  f_out_data;
  logic [4:0]  f_level;
  logic        sw_push;
  logic        sw_pop;
  logic        beat;
  logic        hw_wr;
  logic [14:0] tot;
  logic [14:0] spl;
  logic        split;

  // Bytes for the next transaction: whole rest, or capped per start split
  function automatic logic [14:0] next_len(input logic [14:0] rest,
                                           input logic [14:0] cap,
                                           input logic        is_split);
    if (is_split && (cap < rest))
      next_len = cap;
    else
      next_len = rest;
  endfunction

  assign tot   = w0_q[iso_split_pkg::TOT_LSB +: iso_split_pkg::TOT_W];
  assign spl   = {4'h0, w0_q[iso_split_pkg::SPL_LSB +: iso_split_pkg::SPL_W]};
  assign split = w1_q[iso_split_pkg::SPLIT_BIT];

  desc_mem u_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .raddr_a (addr[3:2]),
    .rdata_a (mem_rd_a),
    .raddr_b (mem_raddr_b),
    .rdata_b (mem_rd_b)
  );

  byte_fifo #(
    .WIDTH (iso_split_pkg::BYTE_W),
    .DEPTH (iso_split_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // Descriptor store: write-back has priority; software writes then are dropped
  assign hw_wr = (state_q == iso_split_pkg::ST_WB0) || (state_q == iso_split_pkg::ST_WB3);
  assign mem_we = hw_wr || (wr && (addr[4] == 1'b0));
  always_comb
  begin
    mem_waddr = addr[3:2];
    mem_wdata = wdata;
    if (state_q == iso_split_pkg::ST_WB0)
    begin
      mem_waddr = iso_split_pkg::W_DW0;
      mem_wdata = w0_q;
      mem_wdata[iso_split_pkg::VALID_BIT] = 1'b0;
    end
    else if (state_q == iso_split_pkg::ST_WB3)
    begin
      mem_waddr = iso_split_pkg::W_DW3;
      mem_wdata = w3_q;
      mem_wdata[iso_split_pkg::ACTIVE_BIT] = 1'b0;
      mem_wdata[iso_split_pkg::XFER_W-1:0] = moved_q[iso_split_pkg::XFER_W-1:0];
    end
  end

  always_comb
  begin
    case (state_q)
      iso_split_pkg::ST_F1:    mem_raddr_b = iso_split_pkg::W_DW1;
      iso_split_pkg::ST_F3:    mem_raddr_b = iso_split_pkg::W_DW3;
      default:                 mem_raddr_b = iso_split_pkg::W_DW0;
    endcase
  end

  // Data path: OUT drains to tx, IN fills from rx
  assign sw_push     = wr && (addr == iso_split_pkg::OFS_DATA);
  assign sw_pop      = rd && (addr == iso_split_pkg::OFS_DATA);
  assign rx_ready    = (state_q == iso_split_pkg::ST_DATA) && dir_in_q && f_in_ready;
  assign tx_valid    = (state_q == iso_split_pkg::ST_DATA) && !dir_in_q && f_out_valid;
  assign tx_data     = f_out_data;
  assign f_in_valid  = dir_in_q ? (rx_valid && rx_ready) : sw_push;
  assign f_in_data   = dir_in_q ? rx_data : wdata[7:0];
  assign f_out_ready = dir_in_q ? sw_pop : tx_ready && (state_q == iso_split_pkg::ST_DATA);
  assign beat        = dir_in_q ? (rx_valid && rx_ready) : (tx_valid && tx_ready);

  assign tok_valid = (state_q == iso_split_pkg::ST_TOKEN);
  assign tok_in    = dir_in_q;
  assign tok_split = split;
  assign tok_addr  = w1_q[iso_split_pkg::FA_LSB +: iso_split_pkg::FA_W];
  assign tok_endp  = {w1_q[iso_split_pkg::EP_HI_LSB +: 3], w0_q[iso_split_pkg::EP_LO_BIT]};
  assign tok_len   = chunk_q;
  assign busy      = (state_q != iso_split_pkg::ST_IDLE);
  assign done      = (state_q == iso_split_pkg::ST_WB3);

  // Sequencer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= iso_split_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        iso_split_pkg::ST_IDLE:
          if (ctrl_q[iso_split_pkg::CTRL_EN_BIT])
            state_q <= iso_split_pkg::ST_F0;
        iso_split_pkg::ST_F0:  state_q <= iso_split_pkg::ST_F1;
        iso_split_pkg::ST_F1:  state_q <= iso_split_pkg::ST_F3;
        iso_split_pkg::ST_F3:  state_q <= iso_split_pkg::ST_CHK;
        iso_split_pkg::ST_CHK:
          if (!w0_q[iso_split_pkg::VALID_BIT])
            state_q <= iso_split_pkg::ST_IDLE;
          else if (tot == 15'h0000)
            state_q <= iso_split_pkg::ST_WB0;
          else if (split && (spl == 15'h0000))
            state_q <= iso_split_pkg::ST_WB0;
          else
            state_q <= iso_split_pkg::ST_TOKEN;
        iso_split_pkg::ST_TOKEN:
          if (fatal_err)
            state_q <= iso_split_pkg::ST_WB0;
          else if (tok_ready)
            state_q <= iso_split_pkg::ST_DATA;
        iso_split_pkg::ST_DATA:
          if (fatal_err)
            state_q <= iso_split_pkg::ST_WB0;
          else if (beat && (chunk_q == 15'h0001))
            state_q <= (remain_q == 15'h0001) ? iso_split_pkg::ST_WB0
                                              : iso_split_pkg::ST_TOKEN;
        iso_split_pkg::ST_WB0: state_q <= iso_split_pkg::ST_WB3;
        iso_split_pkg::ST_WB3: state_q <= iso_split_pkg::ST_IDLE;
        default:               state_q <= iso_split_pkg::ST_IDLE;
      endcase
    end
  end

  // Descriptor capture, reserved bits kept as read
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      w0_q     <= 32'h0000_0000;
      w1_q     <= 32'h0000_0000;
      w3_q     <= 32'h0000_0000;
      dir_in_q <= 1'b0;
    end
    else
    begin
      if (state_q == iso_split_pkg::ST_F1)
        w0_q <= mem_rd_b;
      if (state_q == iso_split_pkg::ST_F3)
        w1_q <= mem_rd_b;
      if (state_q == iso_split_pkg::ST_CHK)
      begin
        w3_q <= mem_rd_b;
        if (w0_q[iso_split_pkg::VALID_BIT])
          dir_in_q <= (w1_q[iso_split_pkg::TOKEN_LSB +: 2] == iso_split_pkg::TOKEN_IN);
      end
    end
  end

  // Byte accounting per transaction and per descriptor
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remain_q <= 15'h0000;
      chunk_q  <= 15'h0000;
      moved_q  <= 15'h0000;
    end
    else if (state_q == iso_split_pkg::ST_CHK)
    begin
      remain_q <= tot;
      chunk_q  <= next_len(tot, spl, split);
      moved_q  <= 15'h0000;
    end
    else if ((state_q == iso_split_pkg::ST_DATA) && beat)
    begin
      remain_q <= remain_q - 15'h0001;
      moved_q  <= moved_q + 15'h0001;
      if (chunk_q == 15'h0001)
        chunk_q <= next_len(remain_q - 15'h0001, spl, split);
      else
        chunk_q <= chunk_q - 15'h0001;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      err_q <= 1'b0;
    else if (state_q == iso_split_pkg::ST_CHK)
      err_q <= 1'b0;
    else if (fatal_err && ((state_q == iso_split_pkg::ST_TOKEN) ||
                           (state_q == iso_split_pkg::ST_DATA)))
      err_q <= 1'b1;
  end

  // Register bus
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_q <= iso_split_pkg::CTRL_RESET;
    else if (wr && (addr == iso_split_pkg::OFS_CTRL))
      ctrl_q <= {31'h0000_0000, wdata[iso_split_pkg::CTRL_EN_BIT]};
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rsel_q <= 3'h0;
      pop_q  <= 9'h000;
    end
    else
    begin
      rsel_q <= 3'h0;
      if (rd)
      begin
        if (addr[4] == 1'b0)
          rsel_q <= 3'h1;
        else if (addr == iso_split_pkg::OFS_CTRL)
          rsel_q <= 3'h2;
        else if (addr == iso_split_pkg::OFS_STAT)
          rsel_q <= 3'h3;
        else if (addr == iso_split_pkg::OFS_DATA)
          rsel_q <= 3'h4;
      end
      if (sw_pop)
        pop_q <= {dir_in_q && f_out_valid, f_out_data};
    end
  end

  always_comb
  begin
    case (rsel_q)
      3'h1:    rdata = mem_rd_a;
      3'h2:    rdata = ctrl_q;
      3'h3:    rdata = {moved_q, f_level, err_q, !f_in_ready, f_out_valid, dir_in_q, 4'h0,
                        busy, state_q == iso_split_pkg::ST_IDLE, 2'h0};
      3'h4:    rdata = {23'h00_0000, pop_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_retire;
    (state_q == iso_split_pkg::ST_WB0) ##1 (state_q == iso_split_pkg::ST_WB3);
  endsequence

  a_token_addr: assert property (tok_valid |-> tok_addr == w1_q[9:3])
    else $error("token address not taken from descriptor");
  a_token_endp: assert property (tok_valid |-> tok_endp == {w1_q[2:0], w0_q[31]})
    else $error("endpoint not reassembled");
  a_split_cap: assert property (tok_valid && split |-> tok_len <= spl)
    else $error("transaction longer than split max length");
  // Only meaningful once CHK has cleared the count and loaded this descriptor's total
  a_total_bound: assert property ((state_q == iso_split_pkg::ST_TOKEN) ||
                                  (state_q == iso_split_pkg::ST_DATA)
                                  |-> moved_q <= tot)
    else $error("moved more than total byte count");
  a_valid_clear: assert property (s_retire |-> $past(mem_we) && !$past(mem_wdata[0]))
    else $error("valid bit not cleared on retire");
  a_err_retire: assert property ((state_q == iso_split_pkg::ST_DATA) && fatal_err
                                 |=> (state_q == iso_split_pkg::ST_WB0) ##1 done)
    else $error("fatal error did not retire descriptor");
  a_skip_idle: assert property ((state_q == iso_split_pkg::ST_CHK) && !w0_q[0]
                                |=> !busy && !tok_valid)
    else $error("inactive descriptor was executed");
  a_dir_token: assert property (tok_valid |-> tok_in == (w1_q[11:10] == 2'h1))
    else $error("token direction mismatch");
  a_hs_whole: assert property ((state_q == iso_split_pkg::ST_CHK) ##1 tok_valid && !split
                               |-> tok_len == tot)
    else $error("high-speed transaction not whole");
  a_active_clr: assert property ((state_q == iso_split_pkg::ST_WB3)
                                 |-> mem_we && !mem_wdata[31] && mem_wdata[30:12] == w3_q[30:12])
    else $error("active clear or reserved bits disturbed");
endmodule

/* File: verilog/iso_split_pkg.sv */
package iso_split_pkg;
  localparam int          AW          = 5;
  localparam int          DW          = 32;
  localparam int          BYTE_W      = 8;
  localparam int          FIFO_DEPTH  = 16;
  // Register byte offsets
  localparam logic [4:0]  OFS_DW0     = 5'h00;
  localparam logic [4:0]  OFS_DW1     = 5'h04;
  localparam logic [4:0]  OFS_DW2     = 5'h08;
  localparam logic [4:0]  OFS_DW3     = 5'h0C;
  localparam logic [4:0]  OFS_CTRL    = 5'h10;
  localparam logic [4:0]  OFS_STAT    = 5'h14;
  localparam logic [4:0]  OFS_DATA    = 5'h18;
  // Descriptor word indices
  localparam logic [1:0]  W_DW0       = 2'h0;
  localparam logic [1:0]  W_DW1       = 2'h1;
  localparam logic [1:0]  W_DW3       = 2'h3;
  // Field positions inside their 32-bit word
  localparam int          FA_LSB      = 3;
  localparam int          FA_W        = 7;
  localparam int          EP_HI_LSB   = 0;
  localparam int          EP_LO_BIT   = 31;
  localparam int          TOKEN_LSB   = 10;
  localparam int          SPLIT_BIT   = 14;
  localparam int          SPL_LSB     = 18;
  localparam int          SPL_W       = 11;
  localparam int          TOT_LSB     = 3;
  localparam int          TOT_W       = 15;
  localparam int          VALID_BIT   = 0;
  localparam int          ACTIVE_BIT  = 31;
  localparam int          XFER_W      = 12;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic [1:0]  TOKEN_OUT   = 2'h0;
  localparam logic [1:0]  TOKEN_IN    = 2'h1;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_IDLE, ST_F0, ST_F1, ST_F3, ST_CHK, ST_TOKEN, ST_DATA, ST_WB0, ST_WB3
  } state_t;
endpackage

/* File: verilog/desc_mem.sv */
`timescale 1ns/1ns
// Four-word descriptor store, one write port and two registered read ports
module desc_mem (
  input  wire logic        mclk,     // Clock
  input  wire logic        reset_n,  // Async reset, active low
  input  wire logic        we,       // Write enable
  input  wire logic [1:0]  waddr,    // Write word index
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [1:0]  raddr_a,  // Software read index
  output logic      [31:0] rdata_a,  // Software read data, registered
  input  wire logic [1:0]  raddr_b,  // Controller read index
  output logic      [31:0] rdata_b   // Controller read data, registered
);
  logic [31:0] mem_q [4];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 4; i++)
        mem_q[i] <= 32'h0000_0000;
    end
    else if (we)
      mem_q[waddr] <= wdata;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_a <= 32'h0000_0000;
      rdata_b <= 32'h0000_0000;
    end
    else
    begin
      rdata_a <= mem_q[raddr_a];
      rdata_b <= mem_q[raddr_b];
    end
  end
endmodule

/* File: verilog/byte_fifo.sv */
`timescale 1ns/1ns
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk,      // Clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic             in_valid,  // Push request
  output logic                  in_ready,  // Not full
  input  wire logic [WIDTH-1:0] in_data,   // Push data
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready, // Pop request
  output logic      [WIDTH-1:0] out_data,  // Head word
  output logic [$clog2(DEPTH):0] level     // Words held
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [PW:0]      wp_q;
  logic [PW:0]      rp_q;
  logic             push;
  logic             pop;

  assign level     = wp_q - rp_q;
  assign in_ready  = (level != (PW+1)'(DEPTH));
  assign out_valid = (wp_q != rp_q);
  assign out_data  = buf_q[rp_q[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk)
  begin
    if (push)
      buf_q[wp_q[PW-1:0]] <= in_data;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule

/* File: tb/fs_device_model.sv */
`timescale 1ns/1ns
// Far-side function: takes tokens, sinks OUT bytes, answers IN tokens with bytes
module fs_device_model (
  input  wire logic        mclk,      // Clock
  input  wire logic        reset_n,   // Async reset, active low
  input  wire logic        slow,      // Answer every other cycle
  input  wire logic        tok_valid, // Token request
  output logic             tok_ready, // Token taken
  input  wire logic        tok_in,    // IN token
  input  wire logic [14:0] tok_len,   // Bytes asked for
  output logic             tx_ready,  // OUT byte taken
  output logic             rx_valid,  // IN byte valid
  input  wire logic        rx_ready,  // IN byte taken
  output logic      [7:0]  rx_data    // IN byte
);
  logic        phase_q;
  logic        rxv_q;
  logic [14:0] owed_q;
  logic [7:0]  next_q;

  assign tok_ready = tok_valid && (!slow || phase_q);
  assign tx_ready  = !slow || phase_q;
  assign rx_valid  = rxv_q;
  // Idle line shows the inverse so a stale byte never passes
  assign rx_data   = rxv_q ? next_q : ~next_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= 1'b0;
    else
      phase_q <= !phase_q;
  end

  // An IN token of n bytes is answered with exactly n bytes
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      owed_q <= 15'h0000;
      next_q <= 8'hA0;
      rxv_q  <= 1'b0;
    end
    else
    begin
      if (tok_valid && tok_ready && tok_in)
        owed_q <= tok_len;
      else if (rxv_q && rx_ready)
        owed_q <= owed_q - 15'h0001;
      if (rxv_q && rx_ready)
        next_q <= next_q + 8'h01;
      if (!rxv_q || rx_ready)
        rxv_q <= (owed_q > {14'h0000, rxv_q}) && (!slow || !phase_q);
    end
  end
endmodule

/* File: tb/iso_split_descriptor_fields_tb.sv */
`timescale 1ns/1ns
module iso_split_descriptor_fields_tb;
  typedef struct packed {
    logic        split;
    logic [1:0]  token;
    logic [6:0]  fa;
    logic [3:0]  ep;
    logic [14:0] total;
    logic [10:0] slen;
    int          ntok;
    logic [14:0] flen;
  } row_t;

  logic        mclk, reset_n, wr, rd, fatal_err, busy, done, slow;
  logic        tok_valid, tok_ready, tok_in, tok_split;
  logic        tx_valid, tx_ready, rx_valid, rx_ready;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [6:0]  tok_addr;
  logic [3:0]  tok_endp;
  logic [14:0] tok_len, flen;
  logic [7:0]  tx_data, rx_data;
  logic [12:0] fsig;
  int          errors, checked, ntok, nout, nin, ndone;

  // Totals stay at or below 1023
  // Other split rows use the whole total as split length; rows 2 and 3 cap it for several splits
  row_t rows [5] = '{
    '{1'b1, iso_split_pkg::TOKEN_OUT, 7'h05, 4'h9, 15'h000C, 11'h00C, 1, 15'h000C},
    '{1'b0, iso_split_pkg::TOKEN_OUT, 7'h40, 4'hE, 15'h0007, 11'h003, 1, 15'h0007},
    '{1'b1, iso_split_pkg::TOKEN_OUT, 7'h2A, 4'hF, 15'h0010, 11'h005, 4, 15'h0005},
    '{1'b1, iso_split_pkg::TOKEN_IN,  7'h7F, 4'h1, 15'h000A, 11'h004, 3, 15'h0004},
    '{1'b0, iso_split_pkg::TOKEN_IN,  7'h01, 4'h0, 15'h0010, 11'h000, 1, 15'h0010}
  };
  row_t fill_row = '{1'b1, iso_split_pkg::TOKEN_OUT, 7'h33, 4'h6, 15'h0010, 11'h010, 1, 15'h0010};
  row_t fat_row  = '{1'b1, iso_split_pkg::TOKEN_IN, 7'h12, 4'h3, 15'h0010, 11'h010, 1, 15'h0010};

  iso_split_descriptor_fields dut_u (
    .mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tok_valid(tok_valid), .tok_ready(tok_ready), .tok_in(tok_in),
    .tok_split(tok_split), .tok_addr(tok_addr), .tok_endp(tok_endp), .tok_len(tok_len),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .fatal_err(fatal_err), .busy(busy), .done(done)
  );

  fs_device_model dev_u (
    .mclk(mclk), .reset_n(reset_n), .slow(slow), .tok_valid(tok_valid),
    .tok_ready(tok_ready), .tok_in(tok_in), .tok_len(tok_len), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic bw(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic br(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] v;
    br(a, v);
    check($sformatf("reg %h", a), v, exp);
  endtask

  task automatic wait_done(input int n0);
    int k;
    for (k = 0; ndone == n0 && k < 600; k++)
      @(posedge mclk);
    if (ndone == n0)
    begin
      errors++;
      $display("MISMATCH done expected 1 seen 0");
      wrap_up();
    end
  endtask

  always @(posedge mclk)
  begin
    if (tok_valid && tok_ready)
    begin
      if (ntok == 0)
      begin
        flen = tok_len;
        fsig = {tok_in, tok_split, tok_addr, tok_endp};
      end
      ntok++;
    end
    if (tx_valid && tx_ready)
    begin
      check("tx byte", 32'(tx_data), 32'h30 + nout);
      nout++;
    end
    if (done)
      ndone++;
  end

  task automatic run(input row_t r, input logic push, input logic sl, input logic fat);
    logic [31:0] d0, d3, v;
    int          t0, k;
    d0 = {r.ep[0], 2'b11, r.slen, r.total, 3'b111};
    d3 = 32'h8010_0000;
    slow <= sl;
    bw(iso_split_pkg::OFS_DW0, d0);
    bw(iso_split_pkg::OFS_DW1, {17'h00000, r.split, 2'b01, r.token, r.fa, r.ep[3:1]});
    bw(iso_split_pkg::OFS_DW2, 32'h00AB_CD00);
    bw(iso_split_pkg::OFS_DW3, d3);
    // Pushes only land while the last latched direction is OUT; the loop pushes for OUT rows only, so IN rows push nothing
    for (k = 0; push && r.token == iso_split_pkg::TOKEN_OUT && k < r.total; k++)
      bw(iso_split_pkg::OFS_DATA, 32'h30 + k);
    t0 = ndone;
    ntok = 0;
    nout = 0;
    bw(iso_split_pkg::OFS_CTRL, 32'h0000_0001);
    if (fat)
    begin
      for (k = 0; !tok_valid && k < 100; k++)
        @(posedge mclk);
      check("token seen", 32'(tok_valid), 32'h0000_0001);
      check("busy", 32'(busy), 32'h0000_0001);
      bw(iso_split_pkg::OFS_CTRL, 32'h0000_0000);
      @(posedge mclk);
      fatal_err <= 1'b1;
      @(posedge mclk);
      fatal_err <= 1'b0;
    end
    wait_done(t0);
    if (fat)
    begin
      br(iso_split_pkg::OFS_STAT, v);
      check("fatal flag", 32'(v[11]), 32'h0000_0001);
    end
    else
    begin
      bw(iso_split_pkg::OFS_CTRL, 32'h0000_0000);
      check("tokens", ntok, r.ntok);
      check("first len", 32'(flen), 32'(r.flen));
      check("fields", 32'(fsig), {19'h0, r.token == iso_split_pkg::TOKEN_IN, r.split, r.fa, r.ep});
      check("out bytes", nout, (r.token == iso_split_pkg::TOKEN_OUT) ? 32'(r.total) : 0);
      for (k = 0; r.token == iso_split_pkg::TOKEN_IN && k < r.total; k++)
      begin
        br(iso_split_pkg::OFS_DATA, v);
        check("in byte", 32'(v[8:0]), 32'h1A0 + nin);
        nin++;
      end
      rc(iso_split_pkg::OFS_DW3, {1'b0, d3[30:12], 12'(r.total)});
    end
    rc(iso_split_pkg::OFS_DW0, d0 & 32'hFFFF_FFFE);
  endtask

  initial
  begin
    logic [31:0] v;
    int          k;
    {reset_n, wr, rd, fatal_err, slow} = 5'h00;
    {addr, wdata} = 37'h0;
    {errors, checked, ntok, nout, nin, ndone} = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    check("busy after reset", 32'(busy), 32'h0000_0000);
    for (k = 0; k < 5; k++)
      rc(5'(4 * k), 32'h0000_0000);
    br(iso_split_pkg::OFS_STAT, v);
    check("idle status", v & 32'h0000_0F0C, 32'h0000_0004);
    bw(5'h1C, 32'hFFFF_FFFF);
    rc(5'h1C, 32'h0000_0000);
    // Descriptor left inactive must never reach the link
    bw(iso_split_pkg::OFS_DW0, 32'h0000_0040);
    bw(iso_split_pkg::OFS_DW1, 32'h0000_4008);
    k = ndone;
    ntok = 0;
    bw(iso_split_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge mclk);
    bw(iso_split_pkg::OFS_CTRL, 32'h0000_0000);
    check("skipped tokens", ntok, 0);
    check("skipped done", ndone - k, 0);
    // One push past full is dropped; drain then runs against a stalling device
    for (k = 0; k < 17; k++)
      bw(iso_split_pkg::OFS_DATA, 32'h30 + k);
    br(iso_split_pkg::OFS_STAT, v);
    check("fifo full", v & 32'h0001_F600, 32'h0001_0600);
    run(fill_row, 1'b0, 1'b1, 1'b0);
    foreach (rows[i])
      run(rows[i], 1'b1, 1'(i % 2), 1'b0);
    run(fat_row, 1'b0, 1'b1, 1'b1);
    wrap_up();
  end
endmodule
